// >>> logic/pbs_cfg.svh
// constants for the parameter block select loader
// assumes one 40 MHz clock and a byte-wide flash read port
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH
`define PBS_BLOCKS        16
`define PBS_BLOCK_BYTES   256
`define PBS_SYS_BLOCK     4'hf
`define PBS_MAX_USER      4'he
`define PBS_MAX_PAIRED    4'hc
`define PBS_MUL_15        8'h0f
`define PBS_OFS_CONFIG    12'h000
`define PBS_OFS_COMMAND   12'h004
`define PBS_OFS_STATUS    12'h008
`define PBS_OFS_ACK       12'h00c
`define PBS_CFG_RESET     8'h00
`define PBS_FLD_MODE_HI   3
`define PBS_FLD_BLK_HI    7
`define PBS_FLD_BLK_LO    4
`define PBS_CMD_LOAD      16'h0300
`define PBS_CMD_SAVE      16'h0301
`define PBS_CMD_ERASE     16'h0302
`define PBS_BLANK_BYTE    8'hff
`endif

// >>> logic/pbs_pkg.sv
// types for the parameter block select loader
// assumes pbs_cfg.svh is on the include path
package pbs_pkg;
  typedef enum logic [3:0] {
    PBS_MODE_DIRECT,
    PBS_MODE_LINK,
    PBS_MODE_ANALOG,
    PBS_MODE_PINS
  } pbs_mode_t;
  typedef enum logic [2:0] {
    PBS_ST_SELECT,
    PBS_ST_LOAD,
    PBS_ST_SAVE,
    PBS_ST_IDLE,
    PBS_ST_STOP
  } pbs_state_t;
endpackage : pbs_pkg

// >>> logic/pbs_loader.sv
// parameter block select and load engine with an apb register port
// assumes a byte flash read/write port with same-cycle answers and a
// byte ram for the working copy; the adc value is already synchronous
//
// Contract
// R1 - flash holds sixteen blocks of 256 bytes each
// R2 - block fifteen holds system data, never a user selection
// R3 - motor only: one block per set, ids zero to fourteen
// R4 - motor plus pfc: two consecutive blocks, even ids zero to twelve
// R5 - config bits 3:0 pick direct, link, analog or pin selection
// R6 - direct mode takes the block from config bits 7:4
// R7 - link commands load a block to ram or save ram to flash
// R8 - analog block is floor of input over reference times 15, max 14
// R9 - four pins form the block number, all ones gives fourteen
// R10 - blank block keeps the device idle and refuses motor start
// R11 - invalid block data flags a load fault and stays idle
// R12 - good block is copied to ram, then the device is stopped
// R13 - each block is rewritten alone, neighbours untouched
// R14 - each accepted link command is echoed as its acknowledgement
// R15 - selection is taken once after reset or a link load command; the code also reselects on a non-link config write while idle or stopped
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pbs_cfg.svh"
module pbs_loader
  import pbs_pkg::*;
#(
  parameter int ADC_BITS = 12,
  parameter bit PFC_PRESENT = 1'b0
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [ADC_BITS-1:0] analog_block_select_pin,
  input  wire logic                block_select_bit0,
  input  wire logic                block_select_bit1,
  input  wire logic                block_select_bit2,
  input  wire logic                block_select_bit3,
  input  wire logic                motor_start_req,
  output logic                     motor_start_ok,
  output logic      [11:0]         flash_addr,
  output logic                     flash_we,
  output logic      [7:0]          flash_wdata,
  input  wire logic [7:0]          flash_rdata,
  output logic      [8:0]          ram_addr,
  output logic                     ram_we,
  output logic      [7:0]          ram_wdata,
  input  wire logic [7:0]          ram_rdata,
  output logic                     load_fault,
  output logic                     dev_idle,
  output logic                     dev_stopped
);

  localparam int NBYTES = `PBS_BLOCK_BYTES;

  // every check in this module runs on pclk and sleeps through reset
  default clocking pbs_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // clamp an arbitrary 4-bit id to a legal user block
  function automatic logic [3:0] legal_block(input logic [3:0] b);
    logic [3:0] r;
    r = (b > `PBS_MAX_USER) ? `PBS_MAX_USER : b; // R2 R3
    if (PFC_PRESENT) begin
      r = (r > `PBS_MAX_PAIRED) ? `PBS_MAX_PAIRED : {r[3:1], 1'b0}; // R4
    end
    return r;
  endfunction

  // pins pass two flops; only the second stage is read
  logic [3:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {block_select_bit3, block_select_bit2,
                   block_select_bit1, block_select_bit0};
      pin_s2_q <= pin_s1_q;
    end
  end

  // analog scaling: floor(v*15 / full scale)
  logic [ADC_BITS+3:0] ana_prod;
  logic [3:0]          ana_blk;
  // four headroom bits keep the product exact, so its top nibble is the block
  assign ana_prod = (ADC_BITS+4)'(analog_block_select_pin) *
                    (ADC_BITS+4)'(`PBS_MUL_15); // R8
  assign ana_blk  = ana_prod[ADC_BITS+3:ADC_BITS];

  // register and engine state
  logic [7:0]  cfg_q, cfg_d;
  pbs_state_t  st_q, st_d;
  logic [3:0]  blk_q, blk_d;
  logic [8:0]  cnt_q, cnt_d;
  logic        pair_q, pair_d;
  logic        fault_q, fault_d;
  logic        blank_q, blank_d;
  logic [7:0]  sum_q, sum_d;
  logic [31:0] ack_q, ack_d;
  logic        ackv_q, ackv_d;
  logic        cmd_busy;

  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire hit_cfg = paddr == `PBS_OFS_CONFIG;
  wire hit_cmd = paddr == `PBS_OFS_COMMAND;
  wire hit_sts = paddr == `PBS_OFS_STATUS;
  wire hit_ack = paddr == `PBS_OFS_ACK;
  wire mapped  = hit_cfg || hit_cmd || hit_sts || hit_ack;
  assign cmd_busy = (st_q == PBS_ST_LOAD) || (st_q == PBS_ST_SAVE) ||
                    (st_q == PBS_ST_SELECT);
  // idle or stopped: nothing in flight, so a fresh selection is safe
  wire resting = (st_q == PBS_ST_IDLE) || (st_q == PBS_ST_STOP);
  wire [15:0] cmd_word = pwdata[15:0];
  wire [15:0] cmd_val  = pwdata[31:16];
  wire cmd_ok = cfg_q[`PBS_FLD_MODE_HI:0] == PBS_MODE_LINK && !cmd_busy &&
                (cmd_word == `PBS_CMD_LOAD || cmd_word == `PBS_CMD_SAVE);
  wire cmd_take = wr_acc && hit_cmd && cmd_ok;

  // apb: zero wait states, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (hit_cfg) prdata = {24'h00_0000, cfg_q};
      if (hit_sts) prdata = {24'h00_0000, blk_q, 1'b0,
                             fault_q, st_q == PBS_ST_IDLE,
                             st_q == PBS_ST_STOP};
      if (hit_ack) prdata = ack_q; // R14
    end
  end

  // main engine next state
  always_comb begin
    logic [3:0] sel;
    sel      = 4'h0;
    cfg_d    = cfg_q;
    st_d     = st_q;
    blk_d    = blk_q;
    cnt_d    = cnt_q;
    pair_d   = pair_q;
    fault_d  = fault_q;
    blank_d  = blank_q;
    sum_d    = sum_q;
    ack_d    = ack_q;
    ackv_d   = ackv_q;
    if (wr_acc && hit_cfg) cfg_d = pwdata[7:0];
    case (st_q)
      PBS_ST_SELECT: begin // R15
        case (cfg_q[`PBS_FLD_MODE_HI:0]) // R5
          PBS_MODE_DIRECT: sel = cfg_q[`PBS_FLD_BLK_HI:`PBS_FLD_BLK_LO]; // R6
          PBS_MODE_ANALOG: sel = ana_blk; // R8
          PBS_MODE_PINS:   sel = pin_s2_q; // R9
          default:         sel = blk_q;
        endcase
        blk_d   = legal_block(sel);
        cnt_d   = 9'h000;
        pair_d  = 1'b0;
        blank_d = 1'b1;
        sum_d   = 8'h00;
        fault_d = 1'b0;
        // link mode waits for a load command instead of autoloading
        st_d = (cfg_q[`PBS_FLD_MODE_HI:0] == PBS_MODE_LINK) ?
               PBS_ST_IDLE : PBS_ST_LOAD;
      end
      PBS_ST_LOAD, PBS_ST_SAVE: begin // R7 R13
        if (st_q == PBS_ST_LOAD) begin
          blank_d = blank_q && (flash_rdata == `PBS_BLANK_BYTE);
          sum_d   = sum_q + flash_rdata;
        end
        cnt_d = cnt_q + 9'h001;
        if (cnt_q == 9'(NBYTES - 1)) begin
          cnt_d = 9'h000;
          if (PFC_PRESENT && !pair_q) begin
            pair_d = 1'b1; // R4 second block of the pair
          end else if (st_q == PBS_ST_SAVE) begin
            st_d = PBS_ST_STOP;
          end else if (blank_q && flash_rdata == `PBS_BLANK_BYTE) begin
            st_d = PBS_ST_IDLE; // R10
          end else if ((sum_q + flash_rdata) != 8'h00) begin
            fault_d = 1'b1; // R11
            st_d    = PBS_ST_IDLE;
          end else begin
            st_d = PBS_ST_STOP; // R12
          end
        end
      end
      PBS_ST_IDLE, PBS_ST_STOP: ;
      default: st_d = PBS_ST_SELECT;
    endcase
    // a non-link config write while resting stands for a fresh start-up, so
    // pin and analog modes can be chosen without a reset; a write during a
    // load or save lands in the register but waits for the next start-up
    if (wr_acc && hit_cfg && resting &&
        pwdata[`PBS_FLD_MODE_HI:0] != PBS_MODE_LINK) begin // R15
      st_d = PBS_ST_SELECT;
    end
    if (cmd_take) begin // R7 R14
      ack_d   = pwdata;
      ackv_d  = 1'b1;
      blk_d   = legal_block(cmd_val[3:0]);
      cnt_d   = 9'h000;
      pair_d  = 1'b0;
      blank_d = 1'b1;
      sum_d   = 8'h00;
      fault_d = 1'b0;
      st_d    = (cmd_word == `PBS_CMD_LOAD) ? PBS_ST_LOAD : PBS_ST_SAVE;
    end else if (wr_acc && hit_ack) begin
      ackv_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= `PBS_CFG_RESET;
      st_q    <= PBS_ST_SELECT;
      blk_q   <= 4'h0;
      cnt_q   <= 9'h000;
      pair_q  <= 1'b0;
      fault_q <= 1'b0;
      blank_q <= 1'b1;
      sum_q   <= 8'h00;
      ack_q   <= 32'h0000_0000;
      ackv_q  <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      st_q    <= st_d;
      blk_q   <= blk_d;
      cnt_q   <= cnt_d;
      pair_q  <= pair_d;
      fault_q <= fault_d;
      blank_q <= blank_d;
      sum_q   <= sum_d;
      ack_q   <= ack_d;
      ackv_q  <= ackv_d;
    end
  end

  // memory ports: address covers exactly one block, or the pair when PFC_PRESENT is set, never beyond
  wire [3:0] cur_blk = blk_q + {3'b000, pair_q};
  assign flash_addr  = {cur_blk, cnt_q[7:0]}; // R1 R13
  assign flash_we    = st_q == PBS_ST_SAVE; // R13
  assign flash_wdata = ram_rdata;
  assign ram_addr    = {pair_q, cnt_q[7:0]};
  assign ram_we      = st_q == PBS_ST_LOAD; // R12
  assign ram_wdata   = flash_rdata;
  assign load_fault  = fault_q;
  assign dev_idle    = st_q == PBS_ST_IDLE;
  assign dev_stopped = st_q == PBS_ST_STOP;
  assign motor_start_ok = motor_start_req && dev_stopped; // R10

  // engine checks; covers mark the start-up and link save paths the bench should reach
  AST_NO_SYS_BLOCK: assert property ( // R2
    (st_q == PBS_ST_LOAD) |-> blk_q != `PBS_SYS_BLOCK)
    else $error("system block selected");
  AST_IDLE_REFUSE: assert property ( // R10
    dev_idle |-> !motor_start_ok)
    else $error("start granted while idle");
  AST_PAIR_EVEN: assert property ( // R4
    (PFC_PRESENT && st_q == PBS_ST_LOAD) |-> !blk_q[0])
    else $error("odd pair id");
  AST_RESET_SELECT: assert property ( // R15
    $rose(presetn) |-> st_q == PBS_ST_SELECT)
    else $error("no selection after reset");
  AST_SELECT_ONCE: assert property ( // R15
    (st_q == PBS_ST_SELECT) |=> st_q != PBS_ST_SELECT)
    else $error("selection repeated");
  AST_FAULT_IDLE: assert property ( // R11
    $rose(fault_q) |-> dev_idle)
    else $error("fault without idle");
  AST_ACK_ECHO: assert property ( // R14
    cmd_take |=> ackv_q && ack_q == $past(pwdata))
    else $error("ack not echoed");
  AST_CMD_REFUSED: assert property ( // R14
    (wr_acc && hit_cmd && !cmd_ok) |=> ack_q == $past(ack_q))
    else $error("refused command changed the echo");
  AST_LOAD_LEN: assert property ( // R12
    ($rose(st_q == PBS_ST_LOAD) && !PFC_PRESENT) |->
      ##[256:257] st_q != PBS_ST_LOAD)
    else $error("load length wrong");
  AST_DIRECT: assert property ( // R6
    (st_q == PBS_ST_SELECT && !PFC_PRESENT &&
     cfg_q[`PBS_FLD_MODE_HI:0] == PBS_MODE_DIRECT &&
     cfg_q[`PBS_FLD_BLK_HI:`PBS_FLD_BLK_LO] <= `PBS_MAX_USER) |=>
      blk_q == $past(cfg_q[`PBS_FLD_BLK_HI:`PBS_FLD_BLK_LO]))
    else $error("direct block wrong");
  AST_PINS_MAX: assert property ( // R9
    (st_q == PBS_ST_SELECT && (&pin_s2_q) && !PFC_PRESENT &&
     cfg_q[`PBS_FLD_MODE_HI:0] == PBS_MODE_PINS) |=>
      blk_q == `PBS_MAX_USER)
    else $error("pin all ones not fourteen");
  AST_ANALOG_TOP: assert property ( // R8
    (st_q == PBS_ST_SELECT && (&analog_block_select_pin) && !PFC_PRESENT &&
     cfg_q[`PBS_FLD_MODE_HI:0] == PBS_MODE_ANALOG) |=>
      blk_q == `PBS_MAX_USER)
    else $error("analog full scale not fourteen");
  COV_STOP:   cover property ($rose(dev_stopped));
  COV_FAULT:  cover property ($rose(load_fault));
  COV_SAVE:   cover property (st_q == PBS_ST_SAVE);
  COV_PINS:   cover property (st_q == PBS_ST_SELECT &&
    cfg_q[`PBS_FLD_MODE_HI:0] == PBS_MODE_PINS);
  COV_ANALOG: cover property (st_q == PBS_ST_SELECT &&
    cfg_q[`PBS_FLD_MODE_HI:0] == PBS_MODE_ANALOG);
endmodule : pbs_loader
`default_nettype wire

// >>> tb/pbs_mem_model.sv
// byte flash of sixteen parameter blocks plus the byte working ram
// assumes the loader drives addresses and strobes synchronously to pclk
`timescale 1ns/10ps
`default_nettype none
module pbs_mem_model (
  input  wire logic        pclk,
  input  wire logic [11:0] flash_addr,
  input  wire logic        flash_we,
  input  wire logic [7:0]  flash_wdata,
  output logic      [7:0]  flash_rdata,
  input  wire logic [8:0]  ram_addr,
  input  wire logic        ram_we,
  input  wire logic [7:0]  ram_wdata,
  output logic      [7:0]  ram_rdata
);
  logic [7:0] flash_q [4096];
  logic [7:0] ram_q   [512];

  // blocks cycle good, blank, invalid; a good block sums to zero
  function automatic logic [7:0] pat(input int b, input int i);
    logic [7:0] s;
    s = 8'h00;
    if (b % 3 == 1) return 8'hff;
    if (i < 255) return 8'(b * 16 + i * 7 + ((b % 3 == 2 && i == 0) ? 1 : 0));
    for (int k = 0; k < 255; k++) s = s + 8'(b * 16 + k * 7);
    return 8'h00 - s;
  endfunction

  // sixteen blocks of 256 bytes, ram starts cleared
  initial begin
    for (int a = 0; a < 4096; a++) flash_q[a] = pat(a / 256, a % 256);
    for (int a = 0; a < 512; a++) ram_q[a] = 8'h00;
  end

  // reads answer in the same cycle, like the real array
  assign flash_rdata = flash_q[flash_addr];
  assign ram_rdata   = ram_q[ram_addr];

  // byte writes touch only the addressed cell
  always @(posedge pclk) begin
    if (flash_we) flash_q[flash_addr] <= flash_wdata;
    if (ram_we) ram_q[ram_addr] <= ram_wdata;
  end
endmodule // pbs_mem_model
`default_nettype wire

// >>> tb/pbs_loader_tb.sv
// bench for the loader: apb master tasks and directed sequences
// assumes pbs_cfg.svh on the include path and the memory model beside it
`timescale 1ns/10ps
`default_nettype none
`include "pbs_cfg.svh"
module pbs_loader_tb;
  import pbs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, flash_addr;
  logic [31:0] pwdata, prdata, rd;
  logic        start_req, start_ok, flash_we, ram_we, fault, idle, stopped;
  logic [7:0]  flash_wdata, flash_rdata, ram_wdata, ram_rdata;
  logic [8:0]  ram_addr;
  int          failures, tests_run;
  logic [3:0]  blk [3] = '{4'h3, 4'h4, 4'h5};
  logic [7:0]  sts [3] = '{8'h31, 8'h42, 8'h56};
  logic [3:0]  pin_sel;
  logic [11:0] ana_code;
  logic [11:0] codes [2] = '{12'hfff, 12'h700};
  logic [7:0]  ana_sts [2] = '{8'he6, 8'h61};

  pbs_loader u_pbs_loader (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_block_select_pin(ana_code), .block_select_bit0(pin_sel[0]),
    .block_select_bit1(pin_sel[1]), .block_select_bit2(pin_sel[2]),
    .block_select_bit3(pin_sel[3]), .motor_start_req(start_req),
    .motor_start_ok(start_ok), .flash_addr(flash_addr), .flash_we(flash_we),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
    .ram_addr(ram_addr), .ram_we(ram_we), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .load_fault(fault), .dev_idle(idle),
    .dev_stopped(stopped));
  pbs_mem_model u_pbs_mem_model (.pclk(pclk), .flash_addr(flash_addr),
    .flash_we(flash_we), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata), .ram_addr(ram_addr), .ram_we(ram_we),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one apb transfer; data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no bound of its own: only the watchdog ends a missing answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    check("pslverr", {31'h0, pslverr}, {31'h0, a > `PBS_OFS_ACK});
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  // let the engine leave its resting state, then wait for it to rest
  task automatic settle();
    int n;
    n = 0;
    while ((stopped === 1'b1 || idle === 1'b1) && n < 4) begin
      @(posedge pclk);
      n++;
    end
    // no bound here: only the watchdog may end a hung load
    while (!(stopped === 1'b1 || idle === 1'b1)) begin
      @(posedge pclk);
    end
  endtask

  // watchdog sized well above the longest sequence
  initial begin
    #500000;
    failures++;
    conclude();
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; start_req = 1'b0; presetn = 1'b0;
    pin_sel = 4'h0;
    ana_code = 12'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    apb(1'b0, `PBS_OFS_CONFIG, 32'h0, rd);
    check("config reset", rd, 32'h0);
    apb(1'b0, `PBS_OFS_STATUS, 32'h0, rd);
    check("boot status", rd, 32'h01);
    check("ram byte", 32'(u_pbs_mem_model.ram_q[5]), 32'h23);
    start_req <= 1'b1;
    @(posedge pclk);
    check("start ok", 32'(start_ok), 32'h1);
    apb(1'b1, `PBS_OFS_CONFIG, 32'h01, rd);
    // good, blank and invalid blocks through link loads
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `PBS_OFS_COMMAND, {12'h0, blk[k], `PBS_CMD_LOAD}, rd);
      settle();
      apb(1'b0, `PBS_OFS_STATUS, 32'h0, rd);
      check("link status", rd, 32'(sts[k]));
      check("start gate", 32'(start_ok), 32'(k == 0));
      apb(1'b0, `PBS_OFS_ACK, 32'h0, rd);
      check("ack", rd, {12'h0, blk[k], `PBS_CMD_LOAD});
    end
    apb(1'b1, `PBS_OFS_COMMAND, {12'h0, 4'h3, `PBS_CMD_LOAD}, rd);
    settle();
    apb(1'b1, `PBS_OFS_COMMAND, {16'h0107, `PBS_CMD_SAVE}, rd);
    settle();
    check("saved", 32'(u_pbs_mem_model.flash_q[1802]), 32'h76);
    check("left nb", 32'(u_pbs_mem_model.flash_q[1791]), 32'hd9);
    check("right nb", 32'(u_pbs_mem_model.flash_q[2048]), 32'h81);
    // commands outside link mode leave the echo alone
    apb(1'b1, `PBS_OFS_CONFIG, 32'h00, rd);
    apb(1'b1, `PBS_OFS_COMMAND, {12'h0, 4'h4, `PBS_CMD_LOAD}, rd);
    apb(1'b0, `PBS_OFS_ACK, 32'h0, rd);
    check("ack kept", rd, {16'h0107, `PBS_CMD_SAVE});
    apb(1'b0, 12'h010, 32'h0, rd);
    settle();
    // pin mode: all ones reads as fourteen, which holds an invalid block
    pin_sel <= 4'hf;
    apb(1'b1, `PBS_OFS_CONFIG, 32'h03, rd);
    settle();
    apb(1'b0, `PBS_OFS_STATUS, 32'h0, rd);
    check("pin status", rd, 32'he6);
    // analog mode: full scale gives fourteen, 0x700 gives good block six
    for (int k = 0; k < 2; k++) begin
      ana_code <= codes[k];
      apb(1'b1, `PBS_OFS_CONFIG, 32'h02, rd);
      settle();
      apb(1'b0, `PBS_OFS_STATUS, 32'h0, rd);
      check("analog status", rd, 32'(ana_sts[k]));
    end
    check("analog ram", 32'(u_pbs_mem_model.ram_q[5]), 32'h83);
    // second reset in mid-run: the reset config selects block zero again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    apb(1'b0, `PBS_OFS_CONFIG, 32'h0, rd);
    check("config after reset", rd, 32'h0);
    apb(1'b0, `PBS_OFS_STATUS, 32'h0, rd);
    check("status after reset", rd, 32'h01);
    conclude();
  end
endmodule // pbs_loader_tb
`default_nettype wire
